/* sapcm_top.sv */
// Serial audio port configuration, sample capture and clock health monitor
`timescale 1ns/100ps
//--------------------------------------------------------------
// How it works
// - Sample sits at programmable bit-clock offset for input and output
// - Left path: 00 mute, 01 left, 10 right, reset 01
// - Right path: 00 mute, 01 right, 10 left, reset 01
// - Detected rate code: 0 error, 4/6/9/B for 16/32/48/96 kHz
// - Bit clocks per frame counted, low eight bits readable
// - Top two ratio bits readable at bits five and four
// - Auto rate mode: status bit zero flags invalid rate
// - Fixed rate mode: bit zero flags configured versus detected mismatch
// - Ignore setting never masks the rate error flag
// - Bit clock valid when not missing, ratio stable and within 32 to 512
// - Status bit two flags missing bit clock
// - Status bit three shows PLL lock, unlocked when disabled
// - Status bit four flags PLL overrate
// - Status bit five flags bit clock too fast or slow
// - Format selector frames input and output alike
// - Word length selector 16/20/24/32 bits, reset 24
//--------------------------------------------------------------
module sapcm_top
   import sapcm_pkg::*;
#(
   parameter int FIFO_DEPTH = 16
)(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        arst_n,
   // Register port
   input  wire logic [7:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [7:0]  reg_rdata,
   // Serial link pins
   input  wire logic        sclk,
   input  wire logic        lrclk,
   input  wire logic        sdin,
   output logic             sdout,
   // Rate and PLL control
   input  wire logic [3:0]  fs_mode,
   input  wire logic        fs_ignore,
   input  wire logic        pll_enable,
   input  wire logic        pll_lock_in,
   input  wire logic        pll_overrate_in,
   // Sample stream
   output logic             pcm_valid,
   input  wire logic        pcm_ready,
   output logic      [31:0] pcm_left,
   output logic      [31:0] pcm_right,
   output logic             pcm_drop
);
   //-----------------------------------------------------------
   // Pin synchronisers
   //-----------------------------------------------------------
   logic [6:0] meta_q, sync_q;
   logic       sclk_d;
   logic       sclk_s, lr_s, sd_s, pen_s, plock_s, povr_s, ign_s;

   // Two flops on the serial pins, fs_ignore and the PLL inputs; fs_mode is read unsynchronised
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         meta_q <= '0;
         sync_q <= '0;
         sclk_d <= 1'b0;
      end else begin
         meta_q <= {sclk, lrclk, sdin, pll_enable, pll_lock_in, pll_overrate_in, fs_ignore};
         sync_q <= meta_q;
         sclk_d <= sync_q[6];
      end
   end
   assign {sclk_s, lr_s, sd_s, pen_s, plock_s, povr_s, ign_s} = sync_q;

   //-----------------------------------------------------------
   // Configuration registers
   //-----------------------------------------------------------
   logic [7:0] fmt_q, ofs_q, route_q, rdata_q;
   logic [1:0] fsm_rsv_q, st_rsv_q;
   logic [7:0] next_fmt, next_ofs, next_route, next_rdata;
   logic [1:0] next_fsm_rsv, next_st_rsv;
   logic [7:0] fsmon, bckmon, statreg;
   logic [1:0] form, lsel, rsel;
   logic [5:0] wlen;
   logic [8:0] offset;

   assign form   = fmt_q[FMT_FORM_LSB +: 2];
   assign wlen   = wlen_bits(fmt_q[FMT_WLEN_LSB +: 2]);
   assign offset = {fmt_q[FMT_OFS_MSB], ofs_q};
   assign lsel   = route_q[ROUTE_L_LSB +: 2];
   assign rsel   = route_q[ROUTE_R_LSB +: 2];

   // Register writes and reads
   always_comb begin
      next_fmt     = fmt_q;
      next_ofs     = ofs_q;
      next_route   = route_q;
      next_fsm_rsv = fsm_rsv_q;
      next_st_rsv  = st_rsv_q;
      next_rdata   = rdata_q;
      if (reg_wr) begin
         if (reg_addr == ADDR_FMT)        next_fmt     = reg_wdata;
         else if (reg_addr == ADDR_OFS)   next_ofs     = reg_wdata;
         else if (reg_addr == ADDR_ROUTE) next_route   = reg_wdata;
         else if (reg_addr == ADDR_FSMON) next_fsm_rsv = reg_wdata[7:6];
         else if (reg_addr == ADDR_STAT)  next_st_rsv  = reg_wdata[7:6];
      end
      if (reg_rd) begin
         if (reg_addr == ADDR_FMT)         next_rdata = fmt_q;
         else if (reg_addr == ADDR_OFS)    next_rdata = ofs_q;
         else if (reg_addr == ADDR_ROUTE)  next_rdata = route_q;
         else if (reg_addr == ADDR_FSMON)  next_rdata = fsmon;
         else if (reg_addr == ADDR_BCKMON) next_rdata = bckmon;
         else if (reg_addr == ADDR_STAT)   next_rdata = statreg;
         else                              next_rdata = 8'h00;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         fmt_q     <= RST_FMT;
         ofs_q     <= RST_OFS;
         route_q   <= RST_ROUTE;
         fsm_rsv_q <= 2'h0;
         st_rsv_q  <= 2'h0;
         rdata_q   <= RST_MON;
      end else begin
         fmt_q     <= next_fmt;
         ofs_q     <= next_ofs;
         route_q   <= next_route;
         fsm_rsv_q <= next_fsm_rsv;
         st_rsv_q  <= next_st_rsv;
         rdata_q   <= next_rdata;
      end
   end
   assign reg_rdata = rdata_q;

   //-----------------------------------------------------------
   // Frame timing, capture and replay
   //-----------------------------------------------------------
   logic        lr_q, seen_q, push_q, sdo_q, next_lr, next_seen, next_push, next_sdo;
   logic [9:0]  bitpos_q, ratio_q, rprev_q, next_bitpos, next_ratio, next_rprev;
   logic [15:0] fcyc_q, next_fcyc;
   logic [7:0]  miss_q, per_q, period_q, next_miss, next_per, next_period;
   logic [3:0]  rate_q, next_rate;
   logic [31:0] shl_q, shr_q, next_shl, next_shr;
   logic [63:0] tx_q, pdat_q, next_tx, next_pdat;
   logic        sclk_rise, sclk_fall, frame_start, in_l, in_r, rate_err, missing;
   logic [10:0] bp, half, base, ls, rs;
   logic [4:0]  idx;

   assign sclk_rise = sclk_s & ~sclk_d;
   assign sclk_fall = ~sclk_s & sclk_d;
   assign missing   = (miss_q >= 8'(SCLK_MISS_CYC));
   // frame begins on falling edge for I2S, rising otherwise
   assign frame_start = sclk_rise &
                        ((form == FORM_I2S) ? (lr_q & ~lr_s) : (~lr_q & lr_s));

   // Data windows inside the frame
   always_comb begin
      half = 11'(ratio_q >> 1);
      if (form == FORM_I2S)                       base = 11'h001;
      else if (form == FORM_RTJ && half > 11'(wlen)) base = half - 11'(wlen);
      else                                        base = 11'h000;
      ls   = base + 11'(offset);
      rs   = (form == FORM_TDM) ? ls + 11'(wlen) : ls + half;
      bp   = frame_start ? 11'h000 :
             ((bitpos_q == 10'h3FF) ? 11'h3FF : 11'(bitpos_q) + 11'h001);
      in_l = (bp >= ls) && (bp < ls + 11'(wlen));
      in_r = (bp >= rs) && (bp < rs + 11'(wlen));
      // A fall prepares the bit at position bp, one ahead of bitpos_q
      idx  = in_l ? 5'(ls + 11'(wlen) - 11'h001 - bp)
                  : 5'(rs + 11'(wlen) - 11'h001 - bp);
   end

   // Link state next values
   always_comb begin
      next_lr     = lr_q;
      next_seen   = seen_q;
      next_push   = 1'b0;
      next_sdo    = sdo_q;
      next_bitpos = bitpos_q;
      next_ratio  = ratio_q;
      next_rprev  = rprev_q;
      next_fcyc   = (fcyc_q == 16'hFFFF) ? fcyc_q : fcyc_q + 16'h0001;
      next_miss   = (miss_q == 8'hFF) ? miss_q : miss_q + 8'h01;
      next_per    = (per_q == 8'hFF) ? per_q : per_q + 8'h01;
      next_period = period_q;
      next_rate   = missing ? RATE_ERR : rate_q;
      next_shl    = shl_q;
      next_shr    = shr_q;
      next_tx     = tx_q;
      next_pdat   = pdat_q;
      if (sclk_rise) begin
         next_lr     = lr_s;
         next_miss   = 8'h00;
         next_per    = 8'h01;
         next_period = per_q;
         next_bitpos = 10'(bp);
         next_shl    = frame_start ? 32'h0 : shl_q;
         next_shr    = frame_start ? 32'h0 : shr_q;
         if (in_l) next_shl = {next_shl[30:0], sd_s};
         if (in_r) next_shr = {next_shr[30:0], sd_s};
      end
      if (frame_start) begin
         // bit clocks in the frame just ended
         next_ratio = bitpos_q + 10'h001;
         next_rprev = ratio_q;
         next_fcyc  = 16'h0001;
         next_rate  = rate_decode(fcyc_q);
         next_seen  = 1'b1;
         next_push  = seen_q;
         next_pdat[63:32] = route(lsel, shl_q, shr_q);
         next_pdat[31:0]  = route(rsel, shr_q, shl_q);
         // Ignore lets data through a rate error; the flag still rises
         if (rate_err && !ign_s) next_pdat = 64'h0;
         next_tx    = next_pdat;
      end
      // replay routed sample at the same offset
      if (sclk_fall) begin
         if (in_l)      next_sdo = tx_q[32 + idx];
         else if (in_r) next_sdo = tx_q[idx];
         else           next_sdo = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         lr_q     <= 1'b0;
         seen_q   <= 1'b0;
         push_q   <= 1'b0;
         sdo_q    <= 1'b0;
         bitpos_q <= '0;
         ratio_q  <= '0;
         rprev_q  <= '0;
         fcyc_q   <= '0;
         miss_q   <= '0;
         per_q    <= '0;
         period_q <= '0;
         rate_q   <= RATE_ERR;
         shl_q    <= '0;
         shr_q    <= '0;
         tx_q     <= '0;
         pdat_q   <= '0;
      end else begin
         lr_q     <= next_lr;
         seen_q   <= next_seen;
         push_q   <= next_push;
         sdo_q    <= next_sdo;
         bitpos_q <= next_bitpos;
         ratio_q  <= next_ratio;
         rprev_q  <= next_rprev;
         fcyc_q   <= next_fcyc;
         miss_q   <= next_miss;
         per_q    <= next_per;
         period_q <= next_period;
         rate_q   <= next_rate;
         shl_q    <= next_shl;
         shr_q    <= next_shr;
         tx_q     <= next_tx;
         pdat_q   <= next_pdat;
      end
   end
   assign sdout = sdo_q;

   //-----------------------------------------------------------
   // Clock health flags and monitor registers
   //-----------------------------------------------------------
   logic [5:0] flags_q, next_flags;

   // auto mode flags invalid rate, fixed mode flags mismatch
   assign rate_err = (fs_mode == 4'h0) ? (rate_q == RATE_ERR) : (rate_q != fs_mode);

   always_comb begin
      // ignore setting is not part of this flag
      next_flags[0] = rate_err;
      next_flags[1] = (ratio_q == rprev_q) && (ratio_q >= RATIO_MIN) &&
                      (ratio_q <= RATIO_MAX) && !missing;
      next_flags[2] = missing;
      next_flags[3] = pen_s & plock_s;
      next_flags[4] = povr_s;
      // bit clock over or under rate
      next_flags[5] = missing || (period_q < 8'(SCLK_MIN_CYC)) ||
                      (period_q > 8'(SCLK_MAX_CYC));
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) flags_q <= '0;
      else         flags_q <= next_flags;
   end

   // ratio high bits beside the rate code
   assign fsmon   = {fsm_rsv_q, ratio_q[9:8], rate_q};
   assign bckmon  = ratio_q[7:0];
   assign statreg = {st_rsv_q, flags_q};

   //-----------------------------------------------------------
   // Sample FIFO and output stage
   //-----------------------------------------------------------
   sapcm_stream_if #(.WIDTH(64)) s_if ();
   logic        pv_q, drop_q, next_pv, next_drop;
   logic [63:0] pd_q, next_pd;

   assign s_if.wr_valid = push_q;
   assign s_if.wr_data  = pdat_q;
   assign s_if.rd_ready = !pv_q || pcm_ready;

   sapcm_fifo #(.WIDTH(64), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk    (clk),
      .arst_n (arst_n),
      .s      (s_if)
   );

   // Output register refilled when empty or taken
   always_comb begin
      next_pv   = pv_q && !pcm_ready;
      next_pd   = pd_q;
      next_drop = push_q && !s_if.wr_ready;
      if (s_if.rd_ready && s_if.rd_valid) begin
         next_pv = 1'b1;
         next_pd = s_if.rd_data;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pv_q   <= 1'b0;
         pd_q   <= '0;
         drop_q <= 1'b0;
      end else begin
         pv_q   <= next_pv;
         pd_q   <= next_pd;
         drop_q <= next_drop;
      end
   end
   assign pcm_valid = pv_q;
   assign {pcm_left, pcm_right} = pd_q;
   assign pcm_drop  = drop_q;

   //-----------------------------------------------------------
   // Checks
   //-----------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);

   sequence s_frame_end;
      frame_start && seen_q;
   endsequence
   sequence s_rate_bad;
      fs_mode == 4'h0 && rate_q == RATE_ERR;
   endsequence

   a_left_mute: assert property (
      s_frame_end ##0 lsel == PATH_MUTE |=> push_q && pdat_q[63:32] == 32'h0)
      else $error("left mute not zero");
   a_right_swap: assert property (
      s_frame_end ##0 rsel == PATH_SWAP && !rate_err |=> pdat_q[31:0] == $past(shl_q))
      else $error("right swap wrong");
   a_ratio_low: assert property (
      frame_start |=> ##1 bckmon == 8'($past(bitpos_q, 2) + 10'h001))
      else $error("ratio low wrong");
   a_ratio_high: assert property (
      frame_start |=> fsmon[5:4] == 2'(($past(bitpos_q) + 10'h001) >> 8))
      else $error("ratio high wrong");
   a_rate_auto: assert property (
      s_rate_bad |=> statreg[0]) else $error("rate invalid not flagged");
   a_rate_ignore: assert property (
      ign_s && fs_mode != 4'h0 && rate_q != fs_mode |=> statreg[0])
      else $error("ignore masked rate error");
   a_sclk_missing: assert property (
      miss_q == 8'(SCLK_MISS_CYC) |=> statreg[2] && statreg[5])
      else $error("missing clock not flagged");
   a_pll_unlock: assert property (
      !pen_s |=> !statreg[3]) else $error("pll lock while disabled");
   a_sdout_idle: assert property (
      sclk_fall && !in_l && !in_r |=> !sdout) else $error("sdout outside window");
endmodule : sapcm_top

/* sapcm_pkg.sv */
// Shared constants, field layout and helpers of the serial audio port monitor
package sapcm_pkg;
   // ---------------------------------------------
   // Register offsets and reset values
   // ---------------------------------------------
   localparam logic [7:0] ADDR_FMT    = 8'h33;
   localparam logic [7:0] ADDR_OFS    = 8'h34;
   localparam logic [7:0] ADDR_ROUTE  = 8'h35;
   localparam logic [7:0] ADDR_FSMON  = 8'h37;
   localparam logic [7:0] ADDR_BCKMON = 8'h38;
   localparam logic [7:0] ADDR_STAT   = 8'h39;
   localparam logic [7:0] RST_FMT     = 8'h02;
   localparam logic [7:0] RST_OFS     = 8'h00;
   localparam logic [7:0] RST_ROUTE   = 8'h11;
   localparam logic [7:0] RST_MON     = 8'h00;
   // ---------------------------------------------
   // Field positions and codes
   // ---------------------------------------------
   localparam int         FMT_OFS_MSB  = 7;
   localparam int         FMT_FORM_LSB = 4;
   localparam int         FMT_WLEN_LSB = 0;
   localparam int         ROUTE_L_LSB  = 4;
   localparam int         ROUTE_R_LSB  = 0;
   localparam logic [1:0] FORM_I2S     = 2'h0;
   localparam logic [1:0] FORM_TDM     = 2'h1;
   localparam logic [1:0] FORM_RTJ     = 2'h2;
   localparam logic [1:0] PATH_MUTE    = 2'h0;
   localparam logic [1:0] PATH_SAME    = 2'h1;
   localparam logic [1:0] PATH_SWAP    = 2'h2;
   localparam logic [3:0] RATE_ERR     = 4'h0;
   localparam logic [3:0] RATE_16K     = 4'h4;
   localparam logic [3:0] RATE_32K     = 4'h6;
   localparam logic [3:0] RATE_48K     = 4'h9;
   localparam logic [3:0] RATE_96K     = 4'hB;
   localparam logic [9:0] RATIO_MIN    = 10'h020;
   localparam logic [9:0] RATIO_MAX    = 10'h200;
   // ---------------------------------------------
   // Timing
   // ---------------------------------------------
   localparam int CLK_PERIOD_NS   = 40;
   localparam int FRAME_NS_16K    = 62500;
   localparam int FRAME_NS_32K    = 31250;
   localparam int FRAME_NS_48K    = 20833;
   localparam int FRAME_NS_96K    = 10417;
   localparam int RATE_TOL_PCT    = 4;
   localparam int SCLK_MISS_NS    = 2000;
   localparam int SCLK_MIN_PER_NS = 120;
   localparam int SCLK_MAX_PER_NS = 1000;
   localparam int SCLK_MISS_CYC   = (SCLK_MISS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SCLK_MIN_CYC    = (SCLK_MIN_PER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SCLK_MAX_CYC    = SCLK_MAX_PER_NS / CLK_PERIOD_NS;

   // Sample width in bits from the word length code
   function automatic logic [5:0] wlen_bits(input logic [1:0] code);
      case (code)
         2'h0:    wlen_bits = 6'h10;
         2'h1:    wlen_bits = 6'h14;
         2'h2:    wlen_bits = 6'h18;
         default: wlen_bits = 6'h20;
      endcase
   endfunction : wlen_bits

   // Data path selector: mute, own channel or the other one
   function automatic logic [31:0] route(input logic [1:0] sel, input logic [31:0] own,
                                         input logic [31:0] other);
      case (sel)
         PATH_SAME: route = own;
         PATH_SWAP: route = other;
         default:   route = 32'h0000_0000;
      endcase
   endfunction : route

   // True when a frame length lies within tolerance of a nominal frame time
   function automatic logic near(input logic [15:0] len, input int frame_ns);
      int cyc;
      int tol;
      cyc  = frame_ns / CLK_PERIOD_NS;
      tol  = cyc * RATE_TOL_PCT / 100;
      near = (int'(len) >= cyc - tol) && (int'(len) <= cyc + tol);
   endfunction : near

   // Sampling rate code from a frame length in clock cycles
   function automatic logic [3:0] rate_decode(input logic [15:0] len);
      if (near(len, FRAME_NS_16K))      rate_decode = RATE_16K;
      else if (near(len, FRAME_NS_32K)) rate_decode = RATE_32K;
      else if (near(len, FRAME_NS_48K)) rate_decode = RATE_48K;
      else if (near(len, FRAME_NS_96K)) rate_decode = RATE_96K;
      else                              rate_decode = RATE_ERR;
   endfunction : rate_decode
endpackage : sapcm_pkg

/* sapcm_stream_if.sv */
// Stream handshake between the capture logic and the sample FIFO
`timescale 1ns/100ps
interface sapcm_stream_if #(parameter int WIDTH = 64);
   logic             wr_valid;
   logic             wr_ready;
   logic [WIDTH-1:0] wr_data;
   logic             rd_valid;
   logic             rd_ready;
   logic [WIDTH-1:0] rd_data;
   modport fifo (input wr_valid, wr_data, rd_ready, output wr_ready, rd_valid, rd_data);
   modport user (output wr_valid, wr_data, rd_ready, input wr_ready, rd_valid, rd_data);
endinterface : sapcm_stream_if

/* sapcm_fifo.sv */
// Sample FIFO with valid and ready on both sides
`timescale 1ns/100ps
module sapcm_fifo #(
   parameter int WIDTH = 64,
   parameter int DEPTH = 16
)(
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // Stream
   sapcm_stream_if.fifo s
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wp, rp, next_wp, next_rp;
   logic [AW:0]      cnt, next_cnt;
   logic             do_wr, do_rd;

   // Honest full and empty
   assign s.wr_ready = (cnt != FULL);
   assign s.rd_valid = (cnt != '0);
   assign s.rd_data  = mem[rp];

   // Pointer and count update
   always_comb begin
      do_wr    = s.wr_valid && s.wr_ready;
      do_rd    = s.rd_ready && s.rd_valid;
      next_wp  = do_wr ? ((wp == AW'(DEPTH - 1)) ? '0 : wp + 1'b1) : wp;
      next_rp  = do_rd ? ((rp == AW'(DEPTH - 1)) ? '0 : rp + 1'b1) : rp;
      next_cnt = cnt + (AW+1)'(do_wr) - (AW+1)'(do_rd);
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         wp  <= '0;
         rp  <= '0;
         cnt <= '0;
      end else begin
         wp  <= next_wp;
         rp  <= next_rp;
         cnt <= next_cnt;
      end
   end

   // Storage
   always_ff @(posedge clk) begin
      if (do_wr) begin
         mem[wp] <= s.wr_data;
      end
   end

   a_fifo_full_refuse: assert property (@(posedge clk) disable iff (!arst_n)
      s.wr_valid && cnt == FULL && !s.rd_ready |=> cnt == FULL)
      else $error("fifo overflows while full");
   a_fifo_count_up: assert property (@(posedge clk) disable iff (!arst_n)
      do_wr && !do_rd |=> cnt == $past(cnt) + 1'b1) else $error("fifo count wrong");
endmodule : sapcm_fifo

/* sapcm_src.sv */
// Behavioural audio source driving serial frames into the monitor
`timescale 1ns/100ps
module sapcm_src (
   // Control
   input  wire logic        run,
   input  wire logic [23:0] left,
   input  wire logic [23:0] right,
   // Serial pins
   output logic             sclk,
   output logic             lrclk,
   output logic             sdin
);
   int          b;
   int          pos;
   logic [23:0] w;
   // ---------------------------------------------
   // Frame generator, 64 bit clocks per frame
   // ---------------------------------------------
   // I2S frame layout
   initial begin
      sclk  = 1'b0;
      lrclk = 1'b1;
      sdin  = 1'b0;
      forever begin
         if (!run) begin
            #320;
         end else begin
            for (b = 0; b < 64; b++) begin
               lrclk = (b >= 32);
               pos   = b % 32;
               w     = (b < 32) ? left : right;
               sdin  = (pos >= 1 && pos <= 24) ? w[24-pos] : ~sdin; // Pad bits toggle
               #160 sclk = 1'b1;
               #160 sclk = 1'b0;
            end
         end
      end
   end
endmodule : sapcm_src

/* sapcm_tb_top.sv */
// Register and stream test of the serial audio port monitor
`timescale 1ns/100ps
module sapcm_tb_top;
   import sapcm_pkg::*;
   logic clk = 1'b0, arst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, run = 1'b0;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
   logic sclk, lrclk, sdin, sdout, pcm_valid, pcm_drop, pcm_ready = 1'b1;
   logic fs_ignore = 1'b0, pll_enable = 1'b0, pll_lock_in = 1'b1, pll_overrate_in = 1'b0;
   logic [3:0] fs_mode = 4'h0;
   logic [31:0] pcm_left, pcm_right;
   int fail_count = 0, check_count = 0, drops = 0;
   always #20 clk = ~clk;
   // Counts dropped frames away from the launching edge
   always @(negedge clk) if (pcm_drop === 1'b1) drops++;
   sapcm_src sapcm_src_i (.run(run), .left(24'hABCDEF), .right(24'h123456), .sclk(sclk),
      .lrclk(lrclk), .sdin(sdin));
   sapcm_top #(.FIFO_DEPTH(16)) sapcm_top_i (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .sclk(sclk), .lrclk(lrclk), .sdin(sdin), .sdout(sdout), .fs_mode(fs_mode),
      .fs_ignore(fs_ignore), .pll_enable(pll_enable), .pll_lock_in(pll_lock_in),
      .pll_overrate_in(pll_overrate_in), .pcm_valid(pcm_valid), .pcm_ready(pcm_ready),
      .pcm_left(pcm_left), .pcm_right(pcm_right), .pcm_drop(pcm_drop));
   // ---------------------------------------------
   // Access and compare tasks
   // ---------------------------------------------
   task automatic stop_test;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : stop_test
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         fail_count++;
         $display("[FAIL] %s exp %h got %h", n, e, g);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr    <= 1'b0;
   endtask : wr
   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd   <= 1'b0;
      @(posedge clk);
      #1 chk($sformatf("reg %h", a), {24'h0, e}, {24'h0, reg_rdata});
   endtask : rchk
   // Waits for one stream word and compares both channels
   task automatic pchk(input logic [31:0] l, input logic [31:0] r);
      int n;
      n = 0;
      @(posedge clk);
      #1;
      while (pcm_valid !== 1'b1 && n < 2000) begin
         @(posedge clk);
         #1 n++;
      end
      chk("pcm_valid", 32'h1, {31'h0, pcm_valid});
      chk("pcm_left", l, pcm_left);
      chk("pcm_right", r, pcm_right);
      @(posedge clk);
   endtask : pchk
   // Captures one frame of sdout at the bit clock rise and compares both windows
   task automatic schk(input logic [23:0] l, input logic [23:0] r);
      logic [63:0] f;
      @(negedge lrclk);
      for (int i = 0; i < 64; i++) begin
         @(posedge sclk);
         f[63-i] = sdout;
      end
      chk("sdout_left", {8'h00, l}, {8'h00, f[62:39]});
      chk("sdout_right", {8'h00, r}, {8'h00, f[30:7]});
   endtask : schk
   // ---------------------------------------------
   // Test sequence and watchdog
   // ---------------------------------------------
   initial begin
      #2400000;
      fail_count++;
      stop_test();
   end
   initial begin
      repeat (20) @(posedge clk);
      arst_n <= 1'b1;
      repeat (60) @(posedge clk);
      rchk(ADDR_FMT, 8'h02);
      rchk(ADDR_OFS, 8'h00);
      rchk(ADDR_ROUTE, 8'h11);
      rchk(ADDR_FSMON, 8'h00);
      rchk(ADDR_STAT, 8'h25);
      wr(ADDR_BCKMON, 8'hFF);
      rchk(ADDR_BCKMON, 8'h00);
      run        <= 1'b1;
      pll_enable <= 1'b1;
      repeat (2600) @(posedge clk);
      rchk(ADDR_FSMON, 8'h09);
      rchk(ADDR_BCKMON, 8'h40);
      rchk(ADDR_STAT, 8'h0A);
      pchk(32'h00ABCDEF, 32'h00123456);
      schk(24'hABCDEF, 24'h123456);
      wr(ADDR_ROUTE, 8'h22);
      repeat (1600) @(posedge clk);
      pchk(32'h00123456, 32'h00ABCDEF);
      wr(ADDR_ROUTE, 8'h20);
      repeat (1600) @(posedge clk);
      pchk(32'h00123456, 32'h00000000);
      fs_mode   <= RATE_16K;
      fs_ignore <= 1'b1;
      repeat (10) @(posedge clk);
      rchk(ADDR_STAT, 8'h0B);
      pll_overrate_in <= 1'b1;
      repeat (10) @(posedge clk);
      rchk(ADDR_STAT, 8'h1B);
      pll_enable <= 1'b0;
      repeat (10) @(posedge clk);
      rchk(ADDR_STAT, 8'h13);
      chk("pcm_drop", 32'h0, drops);
      wr(ADDR_ROUTE, 8'h02);
      repeat (1600) @(posedge clk);
      pcm_ready <= 1'b0;
      repeat (10000) @(posedge clk);
      chk("pcm_drop", 32'h1, 32'(drops > 0));
      pcm_ready <= 1'b1;
      pchk(32'h00000000, 32'h00ABCDEF);
      stop_test();
   end
endmodule : sapcm_tb_top
